// [ee_cfg.svh]
`ifndef EE_CFG_SVH
`define EE_CFG_SVH

`define EE_DEV_CODE      4'ha
`define EE_ILL_CODE      4'hb
`define EE_SEL_BITS      3'h0
`define EE_ADDR_W        13
`define EE_PAGE_W        5
`define EE_ADDR_RST      13'h0000
`define EE_CLK_MHZ       100
`define EE_CLK_NS        10
`define EE_TWR_MS        3
`define EE_TWR_CYCLES    (`EE_TWR_MS * 1000 * 1000 * `EE_CLK_MHZ / 1000)
`define EE_FILT_NS       50
`define EE_FILT_CYCLES   ((`EE_FILT_NS + `EE_CLK_NS - 1) / `EE_CLK_NS)
`define EE_BITS_PER_WORD 4'h8

`endif

// [ee_chk.sv]
`timescale 1ns/1ps
module ee_chk #(
   parameter int PROG_CYCLES = 64
) (
   // Clock and reset
   input  wire logic               clk_in,
   input  wire logic               rst_n_in,
   // Bus and array side
   input  wire logic               scl_in,
   input  wire logic               sda_in,
   input  wire logic               sda_out,
   input  wire logic               sda_oe_out,
   input  wire logic [12:0]        mem_rd_addr_out,
   input  wire logic [7:0]         mem_rd_data_in,
   input  wire ee_pkg::ee_mem_wr_t mem_wr_out,
   input  wire logic               standby_out,
   input  wire logic               busy_out
);
   logic [31:0] busy_cnt_q;
   logic [31:0] busy_cnt_d;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // Length of the program cycle is counted here, as it is far beyond a repetition.
   assign busy_cnt_d = busy_out ? busy_cnt_q + 32'h1 : 32'h0;
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         busy_cnt_q <= 32'h0;
      end else begin
         busy_cnt_q <= busy_cnt_d;
      end
   end
   sequence s_prog_end;
      ##[0:2] standby_out;
   endsequence
   od_drive_only_a: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   ack_low_scl_a: assert property ($rose(sda_oe_out) |-> !scl_in)
      else $error("data pin pulled while clock high");
   busy_quiet_a: assert property (busy_out |-> !sda_oe_out)
      else $error("bus answered during program cycle");
   busy_span_a: assert property ($fell(busy_out) |-> busy_cnt_q == PROG_CYCLES)
      else $error("program cycle length wrong");
   prog_not_idle_a: assert property (busy_out |-> !standby_out)
      else $error("standby during program cycle");
   prog_end_idle_a: assert property ($fell(busy_out) |-> s_prog_end)
      else $error("no standby after program cycle");
   prog_after_stop_a: assert property ($rose(busy_out) |-> scl_in && sda_in)
      else $error("program cycle without stop");
   page_fixed_a: assert property (mem_wr_out.en && $past(mem_wr_out.en) |->
      mem_wr_out.addr[12:5] == $past(mem_wr_out.addr[12:5]))
      else $error("page changed within one program cycle");
   idle_released_a: assert property (standby_out && $past(standby_out) |-> !sda_oe_out)
      else $error("data pin pulled in standby");
endmodule

bind ee_slave ee_chk #(.PROG_CYCLES(PROG_CYCLES)) ee_chk_i (.clk_in(clk_in),
   .rst_n_in(rst_n_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe_out(sda_oe_out), .mem_rd_addr_out(mem_rd_addr_out),
   .mem_rd_data_in(mem_rd_data_in), .mem_wr_out(mem_wr_out),
   .standby_out(standby_out), .busy_out(busy_out));

// [ee_line_filter.sv]
`timescale 1ns/1ps
`include "ee_cfg.svh"

module ee_line_filter (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   // Raw line and its clean copy
   input  wire logic line_in,
   output logic      line_out
);

   logic       meta_q;
   logic       sync_q;
   logic [2:0] cnt_q;

   always_ff @(posedge clk_in) begin
      meta_q <= line_in;
      sync_q <= meta_q;
   end

   // A change must persist for the whole suppression time before it is believed.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         line_out <= 1'b1;
         cnt_q    <= 3'h0;
      end else if (sync_q == line_out) begin
         cnt_q <= 3'h0;
      end else if (cnt_q == 3'(`EE_FILT_CYCLES - 1)) begin
         line_out <= sync_q;
         cnt_q    <= 3'h0;
      end else begin
         cnt_q <= cnt_q + 3'h1;
      end
   end

endmodule

// [ee_master.sv]
`timescale 1ns/1ps
module ee_master #(
   parameter int QTR = 25
) (
   // Clock and bus
   input  wire logic clk_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_oe_out
);
   // The master only pulls the data line low; the pull-up gives the high level.
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   task automatic step(input logic scl, input logic oe);
      scl_out = scl;
      sda_oe_out = oe;
      repeat (QTR) @(negedge clk_in);
   endtask
   task automatic start;
      step(scl_out, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
   endtask
   task automatic stop;
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask
   task automatic bit_io(input logic b, output logic r);
      step(1'b0, !b);
      step(1'b1, !b);
      r = sda_in;
      step(1'b1, !b);
      step(1'b0, !b);
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask
   // Nine clocks per byte also close the illegal read.
   task automatic rd_byte(input logic m_ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(!m_ack, r);
   endtask
endmodule

// [ee_pkg.sv]
package ee_pkg;

   typedef enum logic [2:0] {
      EE_ST_IDLE = 3'h0,
      EE_ST_RX   = 3'h1,
      EE_ST_ACK  = 3'h3,
      EE_ST_TX   = 3'h2,
      EE_ST_RACK = 3'h6,
      EE_ST_PROG = 3'h7
   } ee_state_t;

   typedef enum logic [1:0] {
      EE_PH_DEV  = 2'h0,
      EE_PH_AHI  = 2'h1,
      EE_PH_ALO  = 2'h3,
      EE_PH_DATA = 2'h2
   } ee_phase_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } ee_lines_t;

   typedef struct packed {
      logic        en;
      logic [12:0] addr;
      logic [7:0]  data;
   } ee_mem_wr_t;

endpackage

// [ee_slave.sv]
`timescale 1ns/1ps
`include "ee_cfg.svh"

module ee_slave #(
   parameter int PROG_CYCLES = `EE_TWR_CYCLES
) (
   // Clock and reset
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   // Two-wire bus
   input  wire logic              scl_in,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe_out,
   // Nonvolatile array ports
   output logic [12:0]            mem_rd_addr_out,
   input  wire logic [7:0]        mem_rd_data_in,
   output ee_pkg::ee_mem_wr_t     mem_wr_out,
   // Status
   output logic                   standby_out,
   output logic                   busy_out
);

   ee_pkg::ee_lines_t  line_raw;
   ee_pkg::ee_lines_t  line_f;
   ee_pkg::ee_lines_t  line_p_q;
   ee_pkg::ee_state_t  state_q;
   ee_pkg::ee_phase_t  phase_q;
   logic [3:0]         bit_cnt_q;
   logic [7:0]         shift_q;
   logic [12:0]        addr_q;
   logic               rd_q;
   logic               ill_q;
   logic               mack_q;
   logic [7:0]         page_buf [0:31];
   logic [31:0]        valid_q;
   logic [18:0]        prog_cnt_q;
   logic [5:0]         prog_idx_q;
   logic               scl_rise;
   logic               scl_fall;
   logic               start_ev;
   logic               stop_ev;
   logic               rx_done;
   logic               data_wr;
   logic               prog_done;
   logic [1:0]         dev_class;

   // Returns 2 for a normal match, 1 for the illegal code, 0 for no match.
   function automatic logic [1:0] dev_decode(input logic [7:0] b);
      if (b[7:4] == `EE_DEV_CODE && b[3:1] == `EE_SEL_BITS) begin
         dev_decode = 2'h2;
      end else if (b[7:4] == `EE_ILL_CODE && b[3:1] == `EE_SEL_BITS) begin
         dev_decode = 2'h1;
      end else begin
         dev_decode = 2'h0;
      end
   endfunction

   assign line_raw.scl = scl_in;
   assign line_raw.sda = sda_in;

   // Both lines pass a synchroniser and a glitch filter.
   for (genvar i = 0; i < 2; i++) begin : g_filt
      ee_line_filter u_filt (
         .clk_in   (clk_in),
         .rst_n_in (rst_n_in),
         .line_in  (line_raw[i]),
         .line_out (line_f[i])
      );
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         line_p_q <= 2'h3;
      end else begin
         line_p_q <= line_f;
      end
   end

   assign scl_rise = line_f.scl && !line_p_q.scl;
   assign scl_fall = !line_f.scl && line_p_q.scl;
   // Only SDA moving while SCL stays high counts as a condition.
   assign start_ev = line_f.scl && line_p_q.scl && line_p_q.sda && !line_f.sda;
   assign stop_ev  = line_f.scl && line_p_q.scl && !line_p_q.sda && line_f.sda;
   assign rx_done  = (state_q == ee_pkg::EE_ST_RX) && scl_fall &&
                     (bit_cnt_q == `EE_BITS_PER_WORD);
   assign data_wr  = rx_done && (phase_q == ee_pkg::EE_PH_DATA) && !ill_q;
   assign dev_class = dev_decode(shift_q);
   assign prog_done = (state_q == ee_pkg::EE_ST_PROG) &&
                      (prog_cnt_q == 19'(PROG_CYCLES - 1));

   // Bus state machine.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_q    <= ee_pkg::EE_ST_IDLE;
         phase_q    <= ee_pkg::EE_PH_DEV;
         bit_cnt_q  <= 4'h0;
         shift_q    <= 8'h00;
         addr_q     <= `EE_ADDR_RST;
         rd_q       <= 1'b0;
         ill_q      <= 1'b0;
         mack_q     <= 1'b0;
         sda_oe_out <= 1'b0;
      end else if (state_q == ee_pkg::EE_ST_PROG) begin
         // Bus activity, including polling addresses, is not answered here.
         sda_oe_out <= 1'b0;
         if (prog_done) begin
            state_q <= ee_pkg::EE_ST_IDLE;
         end
      end else if (start_ev) begin
         state_q    <= ee_pkg::EE_ST_RX;
         phase_q    <= ee_pkg::EE_PH_DEV;
         bit_cnt_q  <= 4'h0;
         ill_q      <= 1'b0;
         sda_oe_out <= 1'b0;
      end else if (stop_ev) begin
         sda_oe_out <= 1'b0;
         // Buffered bytes start the timed write; anything else is standby.
         state_q <= (valid_q != 32'h0) ? ee_pkg::EE_ST_PROG : ee_pkg::EE_ST_IDLE;
      end else begin
         case (state_q)
            ee_pkg::EE_ST_RX: begin
               if (scl_rise && bit_cnt_q != `EE_BITS_PER_WORD) begin
                  shift_q   <= {shift_q[6:0], line_f.sda};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (rx_done) begin
                  state_q    <= ee_pkg::EE_ST_ACK;
                  sda_oe_out <= 1'b1;
                  case (phase_q)
                     ee_pkg::EE_PH_DEV: begin
                        rd_q    <= shift_q[0];
                        ill_q   <= (dev_class == 2'h1);
                        phase_q <= ee_pkg::EE_PH_AHI;
                        if (dev_class == 2'h0) begin
                           state_q    <= ee_pkg::EE_ST_IDLE;
                           sda_oe_out <= 1'b0;
                        end
                     end
                     ee_pkg::EE_PH_AHI: begin
                        addr_q[12:8] <= shift_q[4:0];
                        phase_q      <= ee_pkg::EE_PH_ALO;
                     end
                     ee_pkg::EE_PH_ALO: begin
                        addr_q[7:0] <= shift_q;
                        phase_q     <= ee_pkg::EE_PH_DATA;
                     end
                     default: begin
                        // Only the in-page bits move, so the page row is kept.
                        addr_q[4:0] <= addr_q[4:0] + 5'h01;
                     end
                  endcase
                  // An illegal write instruction ends at its first address byte, which still loads addr_q[12:8] but gets no acknowledge.
                  if (ill_q) begin
                     state_q    <= ee_pkg::EE_ST_IDLE;
                     sda_oe_out <= 1'b0;
                  end
               end
            end
            ee_pkg::EE_ST_ACK: begin
               if (scl_fall) begin
                  bit_cnt_q <= 4'h0;
                  if (rd_q) begin
                     // Illegal read sends all ones, leaving the line released.
                     shift_q    <= ill_q ? 8'hff : mem_rd_data_in;
                     sda_oe_out <= ill_q ? 1'b0 : !mem_rd_data_in[7];
                     state_q    <= ee_pkg::EE_ST_TX;
                  end else begin
                     sda_oe_out <= 1'b0;
                     state_q    <= ee_pkg::EE_ST_RX;
                  end
               end
            end
            ee_pkg::EE_ST_TX: begin
               if (scl_rise) begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (bit_cnt_q == `EE_BITS_PER_WORD - 4'h1 && !ill_q) begin
                     addr_q <= addr_q + 13'h0001;
                  end
               end else if (scl_fall) begin
                  if (bit_cnt_q == `EE_BITS_PER_WORD) begin
                     sda_oe_out <= 1'b0;
                     state_q    <= ee_pkg::EE_ST_RACK;
                  end else begin
                     shift_q    <= {shift_q[6:0], 1'b1};
                     sda_oe_out <= !shift_q[6];
                  end
               end
            end
            ee_pkg::EE_ST_RACK: begin
               if (scl_rise) begin
                  mack_q <= !line_f.sda;
               end else if (scl_fall) begin
                  bit_cnt_q <= 4'h0;
                  if (mack_q && !ill_q) begin
                     shift_q    <= mem_rd_data_in;
                     sda_oe_out <= !mem_rd_data_in[7];
                     state_q    <= ee_pkg::EE_ST_TX;
                  end else begin
                     // No acknowledge: stay released until the stop or a new start.
                     state_q <= ee_pkg::EE_ST_IDLE;
                  end
               end
            end
            default: begin
               sda_oe_out <= 1'b0;
            end
         endcase
      end
   end

   // Page buffer: later bytes at the same offset overwrite earlier ones.
   always_ff @(posedge clk_in) begin
      if (data_wr) begin
         page_buf[addr_q[4:0]] <= shift_q;
      end
   end

   // Only offsets actually loaded are marked for programming.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         valid_q <= 32'h0;
      end else if (data_wr) begin
         valid_q[addr_q[4:0]] <= 1'b1;
      end else if (prog_done || (start_ev && state_q != ee_pkg::EE_ST_PROG)) begin
         valid_q <= 32'h0;
      end
   end

   // Internal program cycle: copy marked bytes out, then hold busy for the full time.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         prog_cnt_q <= 19'h0;
         prog_idx_q <= 6'h0;
         mem_wr_out <= '0;
      end else if (state_q == ee_pkg::EE_ST_PROG) begin
         prog_cnt_q      <= prog_cnt_q + 19'h1;
         mem_wr_out.en   <= !prog_idx_q[5] && valid_q[prog_idx_q[4:0]];
         mem_wr_out.addr <= {addr_q[12:5], prog_idx_q[4:0]};
         mem_wr_out.data <= page_buf[prog_idx_q[4:0]];
         if (!prog_idx_q[5]) begin
            prog_idx_q <= prog_idx_q + 6'h1;
         end
      end else begin
         prog_cnt_q    <= 19'h0;
         prog_idx_q    <= 6'h0;
         mem_wr_out.en <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         standby_out <= 1'b1;
         busy_out    <= 1'b0;
      end else begin
         standby_out <= (state_q == ee_pkg::EE_ST_IDLE);
         busy_out    <= (state_q == ee_pkg::EE_ST_PROG);
      end
   end

   assign sda_out         = 1'b0;
   assign mem_rd_addr_out = addr_q;

endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   localparam int PROG = 2000;
   logic               clk_in = 1'b0;
   logic               rst_n_in = 1'b0;
   logic               scl, m_oe, sda, sda_out, sda_oe_out, standby_out, busy_out, ack;
   logic [12:0]        rd_addr;
   logic [7:0]         rd_data, d;
   logic [7:0]         mem [8192];
   ee_pkg::ee_mem_wr_t wr;
   int                 bad_count = 0;
   int                 checked = 0;
   int                 wr_cnt = 0;
   always #5 clk_in = ~clk_in;
   assign sda = !(m_oe | sda_oe_out);
   assign rd_data = mem[rd_addr];
   always @(posedge clk_in) begin
      if (wr.en) begin
         mem[wr.addr] <= wr.data;
         wr_cnt <= wr_cnt + 1;
      end
   end
   ee_slave #(.PROG_CYCLES(PROG)) ee_slave_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
      .mem_rd_addr_out(rd_addr), .mem_rd_data_in(rd_data), .mem_wr_out(wr),
      .standby_out(standby_out), .busy_out(busy_out));
   ee_master ee_master_i (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
   task automatic check(input logic [12:0] seen, input logic [12:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wr_hdr(input logic [12:0] a);
      ee_master_i.start();
      ee_master_i.wr_byte(8'ha0, ack);
      check(ack, 1'b1);
      ee_master_i.wr_byte({3'h0, a[12:8]}, ack);
      check(ack, 1'b1);
      ee_master_i.wr_byte(a[7:0], ack);
      check(ack, 1'b1);
   endtask
   // The first poll lands inside the program cycle and must go unanswered.
   task automatic poll;
      ee_master_i.start();
      ee_master_i.wr_byte(8'ha0, ack);
      check(ack, 1'b0);
      for (int n = 0; n < 8 && !ack; n++) begin
         ee_master_i.stop();
         ee_master_i.start();
         ee_master_i.wr_byte(8'ha0, ack);
      end
      check(busy_out, 1'b0);
      ee_master_i.stop();
   endtask
   task automatic t_page;
      wr_cnt = 0;
      wr_hdr(13'h0a3e);
      for (int i = 1; i <= 34; i++) begin
         ee_master_i.wr_byte(i[7:0], ack);
         check(ack, 1'b1);
      end
      ee_master_i.stop();
      poll();
      check(13'(wr_cnt), 13'h0020);
      for (int k = 0; k < 32; k++) begin
         check({5'h00, mem[13'h0a20 + 13'(k)]}, 13'(k + 3));
      end
      check(mem[13'h0a40], 8'h7c);
   endtask
   task automatic t_rw;
      wr_cnt = 0;
      wr_hdr(13'h1fff);
      ee_master_i.wr_byte(8'h5a, ack);
      ee_master_i.stop();
      poll();
      check(13'(wr_cnt), 13'h0001);
      wr_hdr(13'h1fff);
      ee_master_i.start();
      ee_master_i.wr_byte(8'ha1, ack);
      check(ack, 1'b1);
      ee_master_i.rd_byte(1'b1, d);
      check(d, 8'h5a);
      ee_master_i.rd_byte(1'b1, d);
      check(d, 8'h3c);
      ee_master_i.rd_byte(1'b0, d);
      check(d, 8'h3d);
      ee_master_i.stop();
      check(standby_out, 1'b1);
      ee_master_i.start();
      ee_master_i.wr_byte(8'ha1, ack);
      ee_master_i.rd_byte(1'b0, d);
      check(d, 8'h3e);
      ee_master_i.stop();
   endtask
   task automatic t_refuse;
      logic [7:0] bad [3] = '{8'ha2, 8'h20, 8'ha4};
      foreach (bad[i]) begin
         ee_master_i.start();
         ee_master_i.wr_byte(bad[i], ack);
         check(ack, 1'b0);
         check(standby_out, 1'b1);
         ee_master_i.stop();
      end
      ee_master_i.start();
      ee_master_i.wr_byte(8'hb0, ack);
      check(ack, 1'b1);
      ee_master_i.start();
      ee_master_i.wr_byte(8'hb1, ack);
      check(ack, 1'b1);
      ee_master_i.rd_byte(1'b0, d);
      check(d, 8'hff);
      ee_master_i.start();
      ee_master_i.wr_byte(8'ha1, ack);
      ee_master_i.rd_byte(1'b0, d);
      check(d, 8'h3f);
      ee_master_i.stop();
   endtask
   initial begin
      for (int i = 0; i < 8192; i++) begin
         mem[i] = i[7:0] ^ 8'h3c;
      end
      repeat (8) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (10) @(negedge clk_in);
      check(standby_out, 1'b1);
      check(sda_oe_out | busy_out, 1'b0);
      t_page();
      t_rw();
      t_refuse();
      tally_and_finish();
   end
   initial begin
      repeat (95000) @(posedge clk_in);
      bad_count++;
      tally_and_finish();
   end
endmodule
